/* sccdc_top.sv */
/*
  sccdc_top: 8b/10b transmit encoder and receive decoder with special-character
  handling, an apb register slave, a transmit buffer and the receive framer.
  Assumes: one 250 MHz character clock; the line takes o_tx_code at each edge with
  i_tx_line_ready high; the host obeys the legal special code set.
*/
`timescale 1ns/1ps
`default_nettype none
// Function
// [R1] Receiver reports special codes in primary or alternate format per format select.
// [R2] Transmitter accepts primary and alternate special codes alike.
// [R3] End-of-frame code sends K28.5 with polarity from current running disparity.
// [R4] After end-of-frame, next data LSB is 0 at positive, 1 at negative disparity.
// [R5] Receiver never emits end-of-frame; K28.5 decodes as comma or wrong-disparity comma.
// [R6] Code-violation code sends an invalid character that respects disparity.
// [R7] Receiver emits code-violation code only for characters absent from the tables.
// [R8] Forced-negative comma code always sends negative K28.5.
// [R9] Forced-negative code is reported only for negative K28.5 seen at positive disparity.
// [R10] Forced-positive comma code always sends positive K28.5.
// [R11] Forced-positive code is reported only for positive K28.5 seen at negative disparity.
// [R12] Disparity-violation code sends a deliberately wrong-disparity character.
// [R13] Valid character with mismatched disparity yields disparity-violation code and status.
// [R14] Receiver frames characters on the K28.5 comma.
// [R15] Transmitter sends K28.5 fill when no user data is waiting.
// [R16] Host avoids K28.7 or violation before D11.x/D20.x while framing is on.
// [R17] Host presents only defined special codes.
// [R18] Special characters marked by type control; receiver flags them with status 001.
// [R19] Both ends update running disparity after every character by its actual disparity.
module sccdc_top
  import sccdc_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire sccdc_tx_t i_tx_char,
  input wire logic i_tx_valid,
  output logic o_tx_ready,
  input wire logic i_tx_line_ready,
  output logic [9:0] o_tx_code,
  input wire logic [9:0] i_rx_word,
  input wire logic i_rx_word_valid,
  output sccdc_rx_t o_rx_char,
  output logic o_rx_valid
);
  logic [1:0] ctrl_r;
  logic tx_rd_r;
  logic rx_rd_r;
  logic eof_pend_r;
  logic eof_nxt;
  logic [9:0] tx_nxt;
  logic [7:0] d_mod;
  logic k_ok;
  logic [4:0] kx;
  logic [2:0] ky;
  sccdc_tx_t buf_char;
  logic buf_valid;
  logic [9:0] f_word;
  logic f_valid;
  logic f_locked;
  logic [3:0] f_offset;
  sccdc_rx_t dec;
  logic [4:0] rx_x;
  logic [2:0] rx_y;
  logic rx_k;
  logic [3:0] c4d;
  logic f6;
  logic f4;
  logic alt4;
  logic reg_hit;
  logic [31:0] rd_val;

  // encode {y,x}; control forms are built at negative disparity and inverted when positive
  function automatic logic [9:0] encode(input logic [7:0] d, input logic k, input logic rd);
    logic [4:0] x;
    logic [2:0] y;
    logic [5:0] c6;
    logic [3:0] c4;
    logic r;
    logic alt;
    x = d[4:0];
    y = d[7:5];
    r = k ? 1'b0 : rd;
    c6 = (k && x == X_K28) ? K28_6B : ENC6[x];
    if (r && (x == 5'd7 || sccdc_ones({4'h0, c6}) != 4'h3))
      c6 = ~c6;
    r = sccdc_sub_rd(sccdc_ones({4'h0, c6}), 4'h3, r);
    alt = (y == Y_K7) && (k || (!r && x inside {5'd17, 5'd18, 5'd20}) || (r && x inside {5'd11, 5'd13, 5'd14}));
    c4 = alt ? ALT_4B : ENC4[y];
    if (r && (y == 3'd3 || sccdc_ones({6'h00, c4}) != 4'h2))
      c4 = ~c4;
    return (k && rd) ? ~{c6, c4} : {c6, c4};
  endfunction : encode

  // host code for a decoded control character in the selected format
  function automatic logic [7:0] to_host(input logic [4:0] x, input logic [2:0] y, input logic alt_fmt);
    logic [7:0] c;
    c = {y, x}; // R1
    if (!alt_fmt)
      case (x)
        X_K28: c = {5'h00, y};
        X_K23: c = PRI_K23;
        X_K27: c = PRI_K27;
        X_K29: c = PRI_K29;
        X_K30: c = PRI_K30;
        default: c = {y, x};
      endcase
    return c;
  endfunction : to_host

  // apb slave: zero wait states, read data captured in the setup cycle
  assign reg_hit = i_paddr == REG_CTRL || i_paddr == REG_STATUS;
  assign o_pready = 1'b1;
  assign o_pslverr = i_psel && i_penable && !reg_hit;
  assign rd_val = (i_paddr == REG_CTRL) ? {30'h0, ctrl_r} :
    (i_paddr == REG_STATUS) ? {24'h0, f_offset, 1'b0, f_locked, rx_rd_r, tx_rd_r} : 32'h0;

  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      ctrl_r <= CTRL_RESET;
      o_prdata <= 32'h0;
    end
    else
    begin
      if (i_psel && !i_penable)
        o_prdata <= rd_val;
      if (i_psel && i_penable && i_pwrite && i_paddr == REG_CTRL)
        ctrl_r <= i_pwdata[1:0];
    end
  end

  // the buffer absorbs host words while the line stalls
  sccdc_buf #(
    .WIDTH($bits(sccdc_tx_t)),
    .DEPTH(2)
  ) u_txbuf (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_data(i_tx_char),
    .i_valid(i_tx_valid),
    .o_ready(o_tx_ready),
    .o_data(buf_char),
    .o_valid(buf_valid),
    .i_ready(i_tx_line_ready)
  );

  // map primary or alternate host codes onto one control character
  always_comb
  begin
    k_ok = 1'b1;
    kx = X_K28;
    ky = buf_char.data[2:0];
    if (buf_char.data <= SC_PRI_K_LAST) // R2
    begin
      if (buf_char.data[3])
      begin
        ky = Y_K7;
        case (buf_char.data[1:0])
          2'h0: kx = X_K23;
          2'h1: kx = X_K27;
          2'h2: kx = X_K29;
          default: kx = X_K30;
        endcase
      end
    end
    else if (buf_char.data[4:0] == X_K28 || (buf_char.data[7:5] == Y_K7 &&
      buf_char.data[4:0] inside {X_K23, X_K27, X_K29, X_K30})) // R2
    begin
      kx = buf_char.data[4:0];
      ky = buf_char.data[7:5];
    end
    else
      k_ok = 1'b0;
  end

  // the data byte after an end-of-frame carries the disparity in its low y bit
  assign d_mod = eof_pend_r ? {buf_char.data[7:6], ~tx_rd_r, buf_char.data[4:0]} : buf_char.data; // R4

  always_comb
  begin
    tx_nxt = encode({Y_K28_5, X_K28}, 1'b1, tx_rd_r); // R15
    eof_nxt = eof_pend_r;
    if (buf_valid)
    begin
      eof_nxt = 1'b0;
      if (!buf_char.special) // R18
        tx_nxt = encode(d_mod, 1'b0, tx_rd_r);
      else
        case (buf_char.data)
          SC_EOF: eof_nxt = 1'b1; // R3
          SC_VIOL: tx_nxt = tx_rd_r ? ~PAT_VIOL_NEG : PAT_VIOL_NEG; // R6
          SC_KNEG: tx_nxt = K28_5_NEG; // R8
          SC_KPOS: tx_nxt = ~K28_5_NEG; // R10
          SC_RDVIOL: tx_nxt = tx_rd_r ? ~PAT_RDVIOL_NEG : PAT_RDVIOL_NEG; // R12
          default:
            // reserved codes go out as a violation rather than an arbitrary character
            tx_nxt = k_ok ? encode({ky, kx}, 1'b1, tx_rd_r) : (tx_rd_r ? ~PAT_VIOL_NEG : PAT_VIOL_NEG);
        endcase
    end
  end

  // line side: one character per edge the serializer is ready
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_tx_code <= K28_5_NEG;
      tx_rd_r <= 1'b1;
      eof_pend_r <= 1'b0;
    end
    else if (i_tx_line_ready)
    begin
      o_tx_code <= tx_nxt;
      tx_rd_r <= sccdc_rd_after(tx_nxt, tx_rd_r); // R19
      eof_pend_r <= eof_nxt;
    end
  end

  sccdc_framer #(
    .CHAR_W(10)
  ) u_framer (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_word(i_rx_word),
    .i_word_valid(i_rx_word_valid),
    .i_enable(ctrl_r[CTRL_FRAMER_BIT]),
    .o_word(f_word),
    .o_word_valid(f_valid),
    .o_locked(f_locked),
    .o_offset(f_offset)
  );

  // table search; a K28 block received at positive disparity is fully inverted
  always_comb
  begin
    f6 = 1'b0;
    f4 = 1'b0;
    alt4 = 1'b0;
    rx_x = 5'h00;
    rx_y = 3'h0;
    for (int i = 0; i < 32; i++)
      if (f_word[9:4] == ENC6[i] || ((i == 7 || sccdc_ones({4'h0, ENC6[i]}) != 4'h3) && f_word[9:4] == ~ENC6[i]))
      begin
        f6 = 1'b1;
        rx_x = 5'(i);
      end
    if (f_word[9:4] == K28_6B || f_word[9:4] == ~K28_6B)
    begin
      f6 = 1'b1;
      rx_x = X_K28;
    end
    c4d = (f_word[9:4] == ~K28_6B) ? ~f_word[3:0] : f_word[3:0];
    for (int j = 0; j < 8; j++)
      if (c4d == ENC4[j] || ((j == 3 || sccdc_ones({6'h00, ENC4[j]}) != 4'h2) && c4d == ~ENC4[j]))
      begin
        f4 = 1'b1;
        rx_y = 3'(j);
      end
    if (c4d == ALT_4B || c4d == ~ALT_4B)
    begin
      f4 = 1'b1;
      alt4 = 1'b1;
      rx_y = Y_K7;
    end
    rx_k = rx_x == X_K28 ? (f_word[9:4] == K28_6B || f_word[9:4] == ~K28_6B) :
      (alt4 && rx_x inside {X_K23, X_K27, X_K29, X_K30});
    dec.status = rx_k ? ST_SPECIAL : ST_DATA; // R18
    dec.data = rx_k ? to_host(rx_x, rx_y, ctrl_r[CTRL_FMT_BIT]) : {rx_y, rx_x};
    if (f_word == K28_5_NEG && rx_rd_r)
      dec.data = SC_KNEG; // R9
    else if (f_word == ~K28_5_NEG && !rx_rd_r)
      dec.data = SC_KPOS; // R11
    else if (!(f6 && f4) || (encode({rx_y, rx_x}, rx_k, 1'b0) != f_word && encode({rx_y, rx_x}, rx_k, 1'b1) != f_word))
    begin
      dec.status = ST_CODEERR;
      dec.data = SC_VIOL; // R7
    end
    else if (encode({rx_y, rx_x}, rx_k, rx_rd_r) != f_word)
    begin
      dec.status = ST_RDERR;
      dec.data = SC_RDVIOL; // R13
    end
  end

  // decoded characters are registered toward the host
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_rx_char <= '0;
      o_rx_valid <= 1'b0;
      rx_rd_r <= 1'b0;
    end
    else
    begin
      o_rx_valid <= f_valid;
      if (f_valid)
      begin
        o_rx_char <= dec; // R5
        rx_rd_r <= sccdc_rd_after(f_word, rx_rd_r); // R19
      end
    end
  end

  property p_fill;
    @(posedge i_clk) disable iff (!i_reset_n)
    i_tx_line_ready && !buf_valid |=> o_tx_code == ($past(tx_rd_r) ? ~K28_5_NEG : K28_5_NEG);
  endproperty
  a_fill: assert property (p_fill) else $error("fill comma not sent"); // R15

  property p_eof;
    @(posedge i_clk) disable iff (!i_reset_n)
    i_tx_line_ready && buf_valid && buf_char.special && buf_char.data == SC_EOF
      |=> eof_pend_r && o_tx_code == ($past(tx_rd_r) ? ~K28_5_NEG : K28_5_NEG);
  endproperty
  a_eof: assert property (p_eof) else $error("end-of-frame comma wrong"); // R3

  property p_kneg;
    @(posedge i_clk) disable iff (!i_reset_n)
    i_tx_line_ready && buf_valid && buf_char.special && buf_char.data == SC_KNEG |=> o_tx_code == K28_5_NEG;
  endproperty
  a_kneg: assert property (p_kneg) else $error("forced negative comma wrong"); // R8

  property p_kpos;
    @(posedge i_clk) disable iff (!i_reset_n)
    i_tx_line_ready && buf_valid && buf_char.special && buf_char.data == SC_KPOS |=> o_tx_code == ~K28_5_NEG;
  endproperty
  a_kpos: assert property (p_kpos) else $error("forced positive comma wrong"); // R10

  property p_txrd;
    @(posedge i_clk) disable iff (!i_reset_n)
    i_tx_line_ready |=> (sccdc_ones(o_tx_code) > 4'h5 -> tx_rd_r) && (sccdc_ones(o_tx_code) < 4'h5 -> !tx_rd_r);
  endproperty
  a_txrd: assert property (p_txrd) else $error("transmit disparity not tracked"); // R19

  property p_noeof;
    @(posedge i_clk) disable iff (!i_reset_n)
    o_rx_valid && o_rx_char.status == ST_SPECIAL |-> o_rx_char.data != SC_EOF;
  endproperty
  a_noeof: assert property (p_noeof) else $error("receiver emitted end-of-frame"); // R5

  property p_rxneg;
    @(posedge i_clk) disable iff (!i_reset_n)
    f_valid && f_word == K28_5_NEG && rx_rd_r |=> o_rx_valid && o_rx_char.data == SC_KNEG && rx_rd_r;
  endproperty
  a_rxneg: assert property (p_rxneg) else $error("wrong-disparity negative comma missed"); // R9

  property p_rxpos;
    @(posedge i_clk) disable iff (!i_reset_n)
    f_valid && f_word == ~K28_5_NEG && !rx_rd_r |=> o_rx_valid && o_rx_char.data == SC_KPOS && !rx_rd_r;
  endproperty
  a_rxpos: assert property (p_rxpos) else $error("wrong-disparity positive comma missed"); // R11

  property p_codeerr;
    @(posedge i_clk) disable iff (!i_reset_n)
    o_rx_valid && o_rx_char.status == ST_CODEERR |-> o_rx_char.data == SC_VIOL && $past(f_valid);
  endproperty
  a_codeerr: assert property (p_codeerr) else $error("code error without violation code"); // R7

  property p_rderr;
    @(posedge i_clk) disable iff (!i_reset_n)
    o_rx_valid && o_rx_char.data == SC_RDVIOL && o_rx_char.status != ST_DATA |-> o_rx_char.status == ST_RDERR;
  endproperty
  a_rderr: assert property (p_rderr) else $error("disparity violation status wrong"); // R13
endmodule : sccdc_top
`default_nettype wire

/* sccdc_pkg.sv */
/*
  sccdc_pkg: shared constants, code tables, carrier types and disparity helpers
  for the special-character 8b/10b codec.
  Assumes: ten-bit characters are held as {abcdei, fghj}, bit 9 = a = first on the line.
*/
`default_nettype none
package sccdc_pkg;
  // apb register map (byte addresses) and field positions
  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_STATUS = 12'h004;
  localparam int CTRL_FMT_BIT = 0;
  localparam int CTRL_FRAMER_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h2;
  localparam int ST_TX_RD_BIT = 0;
  localparam int ST_RX_RD_BIT = 1;
  localparam int ST_LOCK_BIT = 2;
  localparam int ST_OFS_LSB = 4;
  // host-side special character codes, primary format
  localparam logic [7:0] SC_EOF = 8'h22;
  localparam logic [7:0] SC_VIOL = 8'he0;
  localparam logic [7:0] SC_KNEG = 8'he1;
  localparam logic [7:0] SC_KPOS = 8'he2;
  localparam logic [7:0] SC_RDVIOL = 8'he4;
  localparam logic [7:0] SC_PRI_K_LAST = 8'h0b;
  localparam logic [7:0] PRI_K23 = 8'h08;
  localparam logic [7:0] PRI_K27 = 8'h09;
  localparam logic [7:0] PRI_K29 = 8'h0a;
  localparam logic [7:0] PRI_K30 = 8'h0b;
  // character coordinates x (5b part) and y (3b part)
  localparam logic [4:0] X_K28 = 5'h1c;
  localparam logic [4:0] X_K23 = 5'h17;
  localparam logic [4:0] X_K27 = 5'h1b;
  localparam logic [4:0] X_K29 = 5'h1d;
  localparam logic [4:0] X_K30 = 5'h1e;
  localparam logic [2:0] Y_K7 = 3'h7;
  localparam logic [2:0] Y_K28_5 = 3'h5;
  localparam int EOF_LSB_BIT = 5;
  // receive status values
  localparam logic [2:0] ST_DATA = 3'h0;
  localparam logic [2:0] ST_SPECIAL = 3'h1;
  localparam logic [2:0] ST_RDERR = 3'h6;
  localparam logic [2:0] ST_CODEERR = 3'h7;
  // ten-bit patterns in their negative-disparity form; positive form is the complement
  localparam logic [9:0] K28_5_NEG = 10'h0fa;
  localparam logic [9:0] PAT_VIOL_NEG = 10'h278;
  localparam logic [9:0] PAT_RDVIOL_NEG = 10'h375;
  localparam logic [6:0] COMMA_NEG = 7'h1f;
  localparam logic [5:0] K28_6B = 6'h0f;
  localparam logic [3:0] ALT_4B = 4'h7;
  localparam logic [5:0] ENC6 [32] = '{6'h27, 6'h1d, 6'h2d, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
    6'h39, 6'h25, 6'h15, 6'h34, 6'h0d, 6'h2c, 6'h1c, 6'h17, 6'h1b, 6'h23, 6'h13, 6'h32,
    6'h0b, 6'h2a, 6'h1a, 6'h3a, 6'h33, 6'h26, 6'h16, 6'h36, 6'h0e, 6'h2e, 6'h1e, 6'h2b};
  localparam logic [3:0] ENC4 [8] = '{4'hb, 4'h9, 4'h5, 4'hc, 4'hd, 4'ha, 4'h6, 4'he};

  typedef struct packed {logic special; logic [7:0] data;} sccdc_tx_t;
  typedef struct packed {logic [2:0] status; logic [7:0] data;} sccdc_rx_t;

  function automatic logic [3:0] sccdc_ones(input logic [9:0] v);
    logic [3:0] n;
    n = 4'h0;
    for (int i = 0; i < 10; i++)
      n = n + 4'(v[i]);
    return n;
  endfunction : sccdc_ones

  // disparity after a sub-block: unbalanced blocks set it, balanced ones keep it
  function automatic logic sccdc_sub_rd(input logic [3:0] ones, input logic [3:0] half, input logic rd);
    return (ones > half) ? 1'b1 : ((ones < half) ? 1'b0 : rd);
  endfunction : sccdc_sub_rd

  function automatic logic sccdc_rd_after(input logic [9:0] c, input logic rd);
    logic r6;
    r6 = sccdc_sub_rd(sccdc_ones({4'h0, c[9:4]}), 4'h3, rd);
    return sccdc_sub_rd(sccdc_ones({6'h00, c[3:0]}), 4'h2, r6);
  endfunction : sccdc_rd_after
endpackage : sccdc_pkg
`default_nettype wire

/* sccdc_buf.sv */
/*
  sccdc_buf: small ring buffer with valid/ready on both sides.
  Assumes: one clock; the drain side may hold i_ready low for any time.
*/
`timescale 1ns/1ps
`default_nettype none
module sccdc_buf #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 2
) (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic [WIDTH-1:0] i_data,
  input wire logic i_valid,
  output logic o_ready,
  output logic [WIDTH-1:0] o_data,
  output logic o_valid,
  input wire logic i_ready
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
    $error("sccdc_buf: DEPTH must be a power of two, at least 2");

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW:0] wr_r;
  logic [AW:0] rd_r;
  logic push;
  logic pop;

  // full when pointers differ only in the wrap bit
  assign o_ready = (wr_r ^ rd_r) != {1'b1, {AW{1'b0}}};
  assign o_valid = wr_r != rd_r;
  assign push = i_valid && o_ready;
  assign pop = o_valid && i_ready;
  assign o_data = mem_r[rd_r[AW-1:0]];

  // storage is written only on push, so no reset is needed for it
  always_ff @(posedge i_clk)
  begin
    if (push)
      mem_r[wr_r[AW-1:0]] <= i_data;
  end

  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      wr_r <= '0;
      rd_r <= '0;
    end
    else
    begin
      if (push)
        wr_r <= wr_r + 1'b1;
      if (pop)
        rd_r <= rd_r + 1'b1;
    end
  end
endmodule : sccdc_buf
`default_nettype wire

/* sccdc_framer.sv */
/*
  sccdc_framer: finds character boundaries in an unaligned ten-bit word stream
  by hunting for the seven-bit comma found in K28.5.
  Assumes: words arrive first-bit-in-msb from a deserializer on the character clock.
*/
`timescale 1ns/1ps
`default_nettype none
module sccdc_framer
  import sccdc_pkg::*;
#(
  parameter int CHAR_W = 10
) (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic [CHAR_W-1:0] i_word,
  input wire logic i_word_valid,
  input wire logic i_enable,
  output logic [CHAR_W-1:0] o_word,
  output logic o_word_valid,
  output logic o_locked,
  output logic [3:0] o_offset
);
  if (CHAR_W < 7 || CHAR_W > 16)
    $error("sccdc_framer: CHAR_W must lie between 7 and 16");

  typedef enum logic [1:0] {SCCDC_HUNT = 2'b00, SCCDC_LOCK = 2'b01} sccdc_frm_state_t;

  sccdc_frm_state_t state_r;
  logic [CHAR_W-1:0] prev_r;
  logic [2*CHAR_W-1:0] win;
  logic hit;
  logic [3:0] hit_ofs;
  logic [3:0] ofs_nxt;

  assign win = {prev_r, i_word};

  // lowest matching offset wins; a comma never appears at two offsets in legal traffic
  always_comb
  begin
    hit = 1'b0;
    hit_ofs = 4'h0;
    for (int k = CHAR_W - 1; k >= 0; k--)
      if (win[2*CHAR_W-1-k -: 7] == COMMA_NEG || win[2*CHAR_W-1-k -: 7] == ~COMMA_NEG)
      begin
        hit = 1'b1;
        hit_ofs = 4'(k);
      end
  end

  // realign only while framing is enabled; otherwise the boundary is frozen
  assign ofs_nxt = (i_enable && hit) ? hit_ofs : o_offset; // R14

  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      state_r <= SCCDC_HUNT;
      prev_r <= '0;
      o_offset <= 4'h0;
      o_word <= '0;
      o_word_valid <= 1'b0;
    end
    else
    begin
      o_word_valid <= 1'b0;
      if (i_word_valid)
      begin
        prev_r <= i_word;
        o_offset <= ofs_nxt;
        o_word <= win[2*CHAR_W-1-ofs_nxt -: CHAR_W];
        case (state_r)
          SCCDC_HUNT:
          begin
            if (i_enable && hit)
            begin
              state_r <= SCCDC_LOCK; // R14
              o_word_valid <= 1'b1;
            end
          end
          SCCDC_LOCK:
            o_word_valid <= 1'b1;
          default:
            state_r <= SCCDC_HUNT;
        endcase
      end
    end
  end

  assign o_locked = state_r == SCCDC_LOCK;
endmodule : sccdc_framer
`default_nettype wire

/* sccdc_host_model.sv */
/*
  sccdc_host_model: host controller that offers one character at a time to the transmit buffer.
  Assumes: a one-cycle request strobe from the bench; the buffer may stall the offer for any time.
*/
`timescale 1ns/1ps
`default_nettype none
module sccdc_host_model
  import sccdc_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_req,
  input wire sccdc_tx_t i_char,
  input wire logic i_ready,
  output sccdc_tx_t o_char,
  output logic o_valid
);
  // offer held until taken; after release the data is inverted so stale words never look valid
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_valid <= 1'b0;
      o_char <= '0;
    end
    else if (o_valid && i_ready)
    begin
      o_valid <= 1'b0;
      o_char <= ~o_char;
    end
    else if (i_req)
    begin
      o_valid <= 1'b1;
      o_char <= i_char;
    end
  end
endmodule : sccdc_host_model
`default_nettype wire

/* test_special_char_8b10b_codec.sv */
/*
  test_special_char_8b10b_codec: directed bench for the codec top over apb, host and line sides.
  Assumes: the host model feeds the transmit buffer; the bench plays line and deserializer.
*/
`timescale 1ns/1ps
`default_nettype none
module test_special_char_8b10b_codec
  import sccdc_pkg::*;
;
  logic i_clk = 1'b0;
  logic i_reset_n = 1'b0;
  logic psel = 1'b0, pen = 1'b0, pwr = 1'b0, req = 1'b0, line_rdy = 1'b0, rv = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, tx_ready, h_valid, rx_valid, err;
  logic [9:0] tx_code, rxw = 10'h000;
  sccdc_tx_t req_char = '0, h_char;
  sccdc_rx_t rx_char;
  sccdc_rx_t rxq [$];
  int mismatches = 0, n_compared = 0;
  // defined codes only, no K28.7 or violation ahead of D11/D20
  logic [8:0] tx_c [8] = '{9'h1e1, 9'h1e2, 9'h122, 9'h0b5, 9'h1e0, 9'h1e4, 9'h1bc, 9'h105};
  logic [9:0] tx_e [8] = '{10'h0fa, 10'h305, 10'h0fa, 10'h2a2, 10'h278, 10'h375, 10'h305, 10'h0fa};
  logic [9:0] rx_w [8] = '{10'h0fa, 10'h0fa, 10'h305, 10'h305, 10'h278, 10'h2ad, 10'h2ad, 10'h305};
  logic [10:0] rx_e [7] = '{11'h1e1, 11'h105, 11'h1e2, 11'h7e0, 11'h095, 11'h6e4, 11'h1bc};

  always #2 i_clk = ~i_clk;

  sccdc_top uut (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_tx_char(h_char), .i_tx_valid(h_valid), .o_tx_ready(tx_ready), .i_tx_line_ready(line_rdy),
    .o_tx_code(tx_code), .i_rx_word(rxw), .i_rx_word_valid(rv), .o_rx_char(rx_char), .o_rx_valid(rx_valid));

  sccdc_host_model host (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_req(req), .i_char(req_char),
    .i_ready(tx_ready), .o_char(h_char), .o_valid(h_valid));

  task automatic report_and_stop();
    if (mismatches == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // one apb transfer; waits on pready, takes data and error at that same edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge i_clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge i_clk);
    pen <= 1'b1;
    for (k = 0; k < 20; k++)
    begin
      @(posedge i_clk);
      if (pready === 1'b1)
        break;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    if (k == 20)
      chk(32'h1, 32'h0);
  endtask : apb

  task automatic push(input logic [8:0] c);
    int k;
    @(posedge i_clk);
    req <= 1'b1;
    req_char <= c;
    @(posedge i_clk);
    req <= 1'b0;
    for (k = 0; k < 20; k++)
    begin
      @(posedge i_clk);
      #1;
      if (h_valid === 1'b0)
        break;
    end
    if (k == 20)
    begin
      chk(32'h1, 32'h0);
      report_and_stop();
    end
  endtask : push

  // line takes one character; the code stands from that edge on
  task automatic pulse(input logic [9:0] exp);
    @(posedge i_clk);
    line_rdy <= 1'b1;
    @(posedge i_clk);
    line_rdy <= 1'b0;
    #1;
    chk(32'(tx_code), 32'(exp));
  endtask : pulse

  task automatic send_word(input logic [9:0] w);
    @(posedge i_clk);
    rxw <= w;
    rv <= 1'b1;
    @(posedge i_clk);
    rv <= 1'b0;
    rxw <= ~w;
  endtask : send_word

  // capture every decoded character; the end-of-frame code must never come back
  always @(posedge i_clk)
    if (rx_valid === 1'b1)
    begin
      rxq.push_back(rx_char);
      if (rx_char.status === ST_SPECIAL && rx_char.data === SC_EOF)
        chk(32'(rx_char), 32'h0);
    end

  initial
  begin
    #40000;
    chk(32'h1, 32'h0);
    report_and_stop();
  end

  initial
  begin
    repeat (3) @(posedge i_clk);
    i_reset_n <= 1'b1;
    #1;
    chk(32'(tx_code), 32'(K28_5_NEG));
    apb(1'b0, REG_CTRL, 32'h0);
    chk(rd, 32'h2);
    apb(1'b0, 12'h008, 32'h0);
    chk({rd[30:0], err}, 32'h1);
    apb(1'b1, REG_STATUS, 32'hffffffff);
    // pairs fill the buffer until it refuses, then drain one by one
    for (int i = 0; i < 8; i += 2)
    begin
      push(tx_c[i]);
      push(tx_c[i + 1]);
      chk(32'(tx_ready), 32'h0);
      pulse(tx_e[i]);
      pulse(tx_e[i + 1]);
    end
    // end-of-frame sent at positive disparity leaves it negative, so the next low y bit is forced to 1
    push(9'h122);
    push(9'h000);
    pulse(10'h305);
    pulse(10'h279);
    pulse(10'h305);
    pulse(10'h0fa);
    for (int i = 0; i < 7; i++)
      send_word(rx_w[i]);
    repeat (6) @(posedge i_clk);
    apb(1'b1, REG_CTRL, 32'h3);
    send_word(rx_w[7]);
    // the framer hands out a word only when the next one arrives, so one more word flushes it
    send_word(rx_w[0]);
    repeat (6) @(posedge i_clk);
    chk(32'(rxq.size() >= 7), 32'h1);
    for (int i = 0; i < 7 && rxq.size() >= 7; i++)
      chk(32'(rxq[rxq.size() - 7 + i]), 32'(rx_e[i]));
    apb(1'b0, REG_STATUS, 32'h0);
    chk(rd & 32'h7, 32'h5);
    report_and_stop();
  end
endmodule : test_special_char_8b10b_codec
`default_nettype wire
